// >>> verilog/wwd_top.sv
// Window watchdog with power-on and power-down reset sequencer
`timescale 1ns/1ps
`default_nettype none
module wwd_top #(
    parameter int TICK_DIV = wwd_pkg::TICK_DIV,
    parameter int REACTION_CYCLES = wwd_pkg::REACTION_CYCLES
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Inputs from the system
    input wire logic TRIGGER_IN,
    input wire logic SUPPLY_LOW,
    // Reset output, open drain
    output logic RESET_OUT_N,
    output logic RESET_OUT_N_OE,
    // System enable output, open drain
    output logic SYSTEM_ENABLE_OUT,
    output logic SYSTEM_ENABLE_OUT_OE,
    // Event pulses
    output wwd_pkg::wwd_event_t FAULT_EVENTS
);

    localparam int RW = $clog2(REACTION_CYCLES + 1);

    if (REACTION_CYCLES < 1) begin : g_bad_rc
        $error("wwd_top: REACTION_CYCLES must be at least 1");
    end
    if (TICK_DIV < 4) begin : g_bad_div
        $error("wwd_top: TICK_DIV must be at least 4");
    end

    // ==========================================================
    // Cycle tick
    // ==========================================================
    logic tick;

    wwd_tick_div #(
        .DIV(TICK_DIV)
    ) i_wwd_tick_div (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .tick(tick)
    );

    // ==========================================================
    // Supply comparator synchroniser and dip filter
    // ==========================================================
    logic sup_meta_r;
    logic sup_low_r;
    logic [RW-1:0] dip_cnt_r;
    logic [RW-1:0] dip_cnt_nxt;
    logic supply_bad;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sup_meta_r <= 1'b1;
            sup_low_r <= 1'b1;
        end else begin
            sup_meta_r <= SUPPLY_LOW;
            sup_low_r <= sup_meta_r;
        end
    end

    always_comb begin
        if (!sup_low_r) begin
            dip_cnt_nxt = '0;
        end else if (dip_cnt_r == RW'(REACTION_CYCLES)) begin
            dip_cnt_nxt = dip_cnt_r;
        end else begin
            dip_cnt_nxt = dip_cnt_r + RW'(1);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            dip_cnt_r <= '0;
        end else begin
            dip_cnt_r <= dip_cnt_nxt;
        end
    end

    // Only a dip that outlasts the reaction time counts
    assign supply_bad = (dip_cnt_r == RW'(REACTION_CYCLES));

    // ==========================================================
    // Trigger sampler
    // ==========================================================
    logic [2:0] hist_r;
    logic [2:0] hist_nxt;
    logic trig_valid;

    // Fourth sample is the current input, taken on the tick
    assign trig_valid = tick
        && ({hist_r, TRIGGER_IN} == wwd_pkg::TRIG_PATTERN);

    always_comb begin
        hist_nxt = hist_r;
        if (!RESET_OUT_N) begin
            hist_nxt = wwd_pkg::TRIG_HIST_RST;
        end else if (tick) begin
            hist_nxt = {hist_r[1:0], TRIGGER_IN};
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            hist_r <= wwd_pkg::TRIG_HIST_RST;
        end else begin
            hist_r <= hist_nxt;
        end
    end

    // ==========================================================
    // Window and reset sequencer
    // ==========================================================
    wwd_pkg::wwd_state_t state_r;
    wwd_pkg::wwd_state_t state_nxt;
    logic [wwd_pkg::CNT_W-1:0] cnt_r;
    logic [wwd_pkg::CNT_W-1:0] cnt_nxt;
    logic [wwd_pkg::CNT_W-1:0] cnt_inc;
    logic reset_n_r;
    logic reset_n_nxt;
    logic sen_r;
    logic sen_nxt;
    wwd_pkg::wwd_event_t ev_r;
    wwd_pkg::wwd_event_t ev_nxt;

    assign cnt_inc = cnt_r + wwd_pkg::CNT_W'(1);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        reset_n_nxt = reset_n_r;
        sen_nxt = sen_r;
        ev_nxt = '0;
        if (supply_bad) begin
            state_nxt = wwd_pkg::ST_PWRUP;
            cnt_nxt = '0;
            reset_n_nxt = 1'b0;
            sen_nxt = 1'b0;
            ev_nxt.power_down = (state_r != wwd_pkg::ST_PWRUP);
        end else begin
            unique case (state_r)
                wwd_pkg::ST_PWRUP: begin
                    if (tick) begin
                        cnt_nxt = cnt_inc;
                        if (cnt_inc == wwd_pkg::PWRUP_TICKS) begin
                            state_nxt = wwd_pkg::ST_CLOSED;
                            cnt_nxt = '0;
                            reset_n_nxt = 1'b1;
                        end
                    end
                end
                wwd_pkg::ST_CLOSED: begin
                    if (trig_valid) begin
                        state_nxt = wwd_pkg::ST_FAULT_WAIT;
                        cnt_nxt = cnt_inc;
                        sen_nxt = 1'b0;
                        ev_nxt.pretrigger = 1'b1;
                    end else if (tick) begin
                        cnt_nxt = cnt_inc;
                        if (cnt_inc == wwd_pkg::CLOSED_TICKS) begin
                            state_nxt = wwd_pkg::ST_OPEN;
                        end
                    end
                end
                wwd_pkg::ST_OPEN: begin
                    if (trig_valid) begin
                        // Last low sample inside the open window is good
                        state_nxt = wwd_pkg::ST_CLOSED;
                        cnt_nxt = '0;
                        sen_nxt = 1'b1;
                    end else if (tick) begin
                        cnt_nxt = cnt_inc;
                        if (cnt_inc == wwd_pkg::CLOSED_TICKS
                                + wwd_pkg::OPEN_TICKS) begin
                            // Window start plus 64 ticks: reset now
                            state_nxt = wwd_pkg::ST_FAULT_RST;
                            cnt_nxt = '0;
                            reset_n_nxt = 1'b0;
                            sen_nxt = 1'b0;
                            ev_nxt.missing = 1'b1;
                        end
                    end
                end
                wwd_pkg::ST_FAULT_WAIT: begin
                    if (tick) begin
                        cnt_nxt = cnt_inc;
                        if (cnt_inc == wwd_pkg::FAULT_START_TICKS) begin
                            state_nxt = wwd_pkg::ST_FAULT_RST;
                            cnt_nxt = '0;
                            reset_n_nxt = 1'b0;
                        end
                    end
                end
                wwd_pkg::ST_FAULT_RST: begin
                    if (tick) begin
                        cnt_nxt = cnt_inc;
                        if (cnt_inc == wwd_pkg::FAULT_LEN_TICKS) begin
                            state_nxt = wwd_pkg::ST_CLOSED;
                            cnt_nxt = '0;
                            reset_n_nxt = 1'b1;
                        end
                    end
                end
                default: begin
                    state_nxt = wwd_pkg::ST_PWRUP;
                    cnt_nxt = '0;
                    reset_n_nxt = 1'b0;
                    sen_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= wwd_pkg::ST_PWRUP;
            cnt_r <= '0;
            reset_n_r <= wwd_pkg::RESET_N_RST;
            sen_r <= wwd_pkg::SEN_RST;
            ev_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            reset_n_r <= reset_n_nxt;
            sen_r <= sen_nxt;
            ev_r <= ev_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign RESET_OUT_N = reset_n_r;
    assign RESET_OUT_N_OE = !reset_n_r;
    assign SYSTEM_ENABLE_OUT = sen_r;
    assign SYSTEM_ENABLE_OUT_OE = !sen_r;
    assign FAULT_EVENTS = ev_r;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    // Ticks seen while reset is held low
    logic [wwd_pkg::CNT_W:0] low_ticks_r;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            low_ticks_r <= '0;
        end else if (reset_n_r || supply_bad) begin
            low_ticks_r <= '0;
        end else if (tick) begin
            low_ticks_r <= low_ticks_r + (wwd_pkg::CNT_W+1)'(1);
        end
    end

    sequence s_closed_start;
        reset_n_r && state_r == wwd_pkg::ST_CLOSED && cnt_r == '0;
    endsequence

    sequence s_fault_reset_entry;
        !reset_n_r && state_r == wwd_pkg::ST_FAULT_RST && cnt_r == '0;
    endsequence

    a_reset_low_len: assert property (
        $rose(reset_n_r) |-> low_ticks_r == {1'b0, wwd_pkg::PWRUP_TICKS})
        else $error("reset low time is not 64 ticks");

    a_rise_opens_closed: assert property (
        $rose(reset_n_r) |-> s_closed_start)
        else $error("reset release did not start a closed window");

    a_pretrig_fault: assert property (
        (state_r == wwd_pkg::ST_CLOSED && trig_valid && !supply_bad)
        |=> ev_r.pretrigger && !sen_r
            && state_r == wwd_pkg::ST_FAULT_WAIT)
        else $error("pretrigger not flagged");

    a_closed_to_open: assert property (
        (state_r == wwd_pkg::ST_CLOSED && tick && !trig_valid
            && !supply_bad && cnt_r == wwd_pkg::CLOSED_TICKS - 7'h01)
        |=> state_r == wwd_pkg::ST_OPEN ##0 cnt_r == wwd_pkg::CLOSED_TICKS)
        else $error("closed window did not last 32 ticks");

    a_good_trigger: assert property (
        (state_r == wwd_pkg::ST_OPEN && trig_valid && !supply_bad)
        |=> s_closed_start ##0 sen_r)
        else $error("open window trigger did not restart window");

    a_missing_fault: assert property (
        (state_r == wwd_pkg::ST_OPEN && tick && !trig_valid && !supply_bad
            && cnt_inc == wwd_pkg::CLOSED_TICKS + wwd_pkg::OPEN_TICKS)
        |=> s_fault_reset_entry ##0 !sen_r ##0 ev_r.missing)
        else $error("missing trigger did not reset");

    a_fault_start: assert property (
        (state_r == wwd_pkg::ST_FAULT_WAIT && tick && !supply_bad
            && cnt_inc == wwd_pkg::FAULT_START_TICKS) |=> s_fault_reset_entry)
        else $error("fault reset did not start at 64 ticks");

    a_dip_filter: assert property (
        $rose(supply_bad) |-> $past(sup_low_r) ##1 (!reset_n_r && !sen_r))
        else $error("supply dip did not reset");

    a_short_dip: assert property (
        (reset_n_r && !sup_low_r) |=> !supply_bad)
        else $error("short supply dip was not filtered");

    a_valid_pattern: assert property (
        trig_valid |-> !TRIGGER_IN && !$past(TRIGGER_IN, TICK_DIV)
            && $past(TRIGGER_IN, 2 * TICK_DIV)
            && $past(TRIGGER_IN, 3 * TICK_DIV))
        else $error("trigger decoded without two high and two low samples");

endmodule : wwd_top
`default_nettype wire

// >>> verilog/wwd_pkg.sv
// Shared constants and types for the window watchdog and reset sequencer
package wwd_pkg;

    // ==========================================================
    // Clock and timebase
    // ==========================================================
    localparam int CLK_PERIOD_NS = 10;
    // Oscillator periods per cycle tick
    localparam int TICK_DIV = 100;
    // Supply dip filter, typical figure
    localparam int REACTION_TIME_NS = 100000;
    localparam int REACTION_CYCLES = REACTION_TIME_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Sequence lengths in cycle ticks
    // ==========================================================
    localparam int CNT_W = 7;
    localparam logic [6:0] PWRUP_TICKS = 7'h40;
    localparam logic [6:0] CLOSED_TICKS = 7'h20;
    localparam logic [6:0] OPEN_TICKS = 7'h20;
    localparam logic [6:0] FAULT_START_TICKS = 7'h40;
    localparam logic [6:0] FAULT_LEN_TICKS = 7'h40;

    // ==========================================================
    // Trigger decode and reset values
    // ==========================================================
    // Oldest sample in the high bit: high, high, low, low
    localparam logic [3:0] TRIG_PATTERN = 4'hC;
    localparam logic [2:0] TRIG_HIST_RST = 3'h0;
    localparam logic SEN_RST = 1'h0;
    localparam logic RESET_N_RST = 1'h0;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        ST_PWRUP,
        ST_CLOSED,
        ST_OPEN,
        ST_FAULT_WAIT,
        ST_FAULT_RST
    } wwd_state_t;

    typedef struct packed {
        logic pretrigger;
        logic missing;
        logic power_down;
    } wwd_event_t;

endpackage : wwd_pkg

// >>> verilog/wwd_tick_div.sv
// Cycle tick generator: one pulse every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module wwd_tick_div #(
    parameter int DIV = wwd_pkg::TICK_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Tick
    output logic tick
);

    localparam int W = $clog2(DIV);

    if (DIV < 2) begin : g_bad_div
        $error("wwd_tick_div: DIV must be at least 2");
    end

    // ==========================================================
    // Divider
    // ==========================================================
    logic [W-1:0] div_r;
    logic [W-1:0] div_nxt;

    always_comb begin
        if (div_r == W'(DIV - 1)) begin
            div_nxt = '0;
        end else begin
            div_nxt = div_r + W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    assign tick = (div_r == W'(DIV - 1));

    // ==========================================================
    // Checks
    // ==========================================================
    logic [W:0] gap_r;
    logic seen_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_r <= '0;
            seen_r <= 1'b0;
        end else begin
            gap_r <= tick ? '0 : gap_r + (W+1)'(1);
            seen_r <= seen_r | tick;
        end
    end

    a_tick_spacing: assert property (
        @(posedge clk) disable iff (!rst_n)
        (tick && seen_r) |-> (gap_r == (W+1)'(DIV - 1)))
        else $error("cycle tick spacing differs from divider");

endmodule : wwd_tick_div
`default_nettype wire

// >>> sim/wwd_mcu_model.sv
// Behavioural controller that answers the watchdog with triggers
`timescale 1ns/1ps
`default_nettype none
module wwd_mcu_model #(
    parameter int TD = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watchdog pins
    input wire logic ro_n,
    output logic trig,
    // Tick of the falling edge in each period, zero for never
    input wire logic [7:0] fall_tk
);
    int c;

    // ==========================================================
    // Trigger period: high from its start, then low three ticks
    // ==========================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            c <= 0;
            trig <= 1'b0;
        end else begin
            if (!ro_n || c >= (int'(fall_tk) + 3) * TD - 1) begin
                c <= 0;
            end else begin
                c <= c + 1;
            end
            // Held in reset it drives low; else high for fall_tk ticks, then low
            trig <= ro_n && (fall_tk == 8'h00 || c < int'(fall_tk) * TD);
        end
    end
endmodule : wwd_mcu_model
`default_nettype wire

// >>> sim/tb_window_watchdog_reset_gen.sv
// Self-checking bench for the window watchdog and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_window_watchdog_reset_gen;
    localparam int TD = 4;
    localparam int RC = 20;
    localparam int LO = 63 * TD;
    localparam int HI = 65 * TD + 6;

    logic CORE_CLK;
    logic RST_N;
    logic TRIGGER_IN;
    logic SUPPLY_LOW;
    logic RESET_OUT_N;
    logic RESET_OUT_N_OE;
    logic SYSTEM_ENABLE_OUT;
    logic SYSTEM_ENABLE_OUT_OE;
    wwd_pkg::wwd_event_t FAULT_EVENTS;
    logic ro_pin;
    logic [7:0] fall_tk;
    int n_mismatch;
    int checks;
    int cyc;
    int n_pre;
    int n_miss;
    int n_pd;

    // Open-drain reset line with its pull-up
    assign ro_pin = RESET_OUT_N_OE ? 1'b0 : 1'b1;

    wwd_top #(.TICK_DIV(TD), .REACTION_CYCLES(RC)) i_wwd_top (
        .CORE_CLK(CORE_CLK), .RST_N(RST_N), .TRIGGER_IN(TRIGGER_IN),
        .SUPPLY_LOW(SUPPLY_LOW), .RESET_OUT_N(RESET_OUT_N),
        .RESET_OUT_N_OE(RESET_OUT_N_OE),
        .SYSTEM_ENABLE_OUT(SYSTEM_ENABLE_OUT),
        .SYSTEM_ENABLE_OUT_OE(SYSTEM_ENABLE_OUT_OE),
        .FAULT_EVENTS(FAULT_EVENTS));

    wwd_mcu_model #(.TD(TD)) i_wwd_mcu_model (
        .clk(CORE_CLK), .rst_n(RST_N), .ro_n(ro_pin),
        .trig(TRIGGER_IN), .fall_tk(fall_tk));

    initial CORE_CLK = 1'b0;
    always #5 CORE_CLK = ~CORE_CLK;

    // ==========================================================
    // Event pulse counters and hang limit
    // ==========================================================
    always @(posedge CORE_CLK) begin
        cyc <= cyc + 1;
        if (FAULT_EVENTS.pretrigger === 1'b1) n_pre <= n_pre + 1;
        if (FAULT_EVENTS.missing === 1'b1) n_miss <= n_miss + 1;
        if (FAULT_EVENTS.power_down === 1'b1) n_pd <= n_pd + 1;
        if (cyc == 30000) begin
            n_mismatch = n_mismatch + 1;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // Waits for reset (sel 0) or enable (sel 1) to reach v
    task automatic wait_lvl(input logic sel, input logic v, output int n);
        n = 0;
        while ((sel ? SYSTEM_ENABLE_OUT : RESET_OUT_N) !== v && n < 2000) begin
            @(posedge CORE_CLK);
            n = n + 1;
        end
        chk("awaited level", sel ? SYSTEM_ENABLE_OUT : RESET_OUT_N, v);
    endtask : wait_lvl

    task automatic run(input int n, output int lows);
        lows = 0;
        repeat (n) begin
            @(posedge CORE_CLK);
            if (RESET_OUT_N !== 1'b1) lows = lows + 1;
        end
    endtask : run

    task automatic do_reset(input logic [7:0] f);
        int n;
        @(posedge CORE_CLK);
        RST_N <= 1'b0;
        SUPPLY_LOW <= 1'b0;
        fall_tk <= f;
        repeat (20) @(posedge CORE_CLK);
        chk("reset pin in reset", ro_pin, 1'b0);
        RST_N <= 1'b1;
        wait_lvl(1'b0, 1'b1, n);
        chk("power-up delay", n >= LO && n <= HI, 1'b1);
    endtask : do_reset

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_good(input logic [7:0] f);
        int lows;
        do_reset(f);
        run(4 * (int'(f) + 3) * TD + 8, lows);
        chk("reset lows with triggers", lows, 0);
        chk("enable after trigger", SYSTEM_ENABLE_OUT, 1'b1);
        chk("enable pin released", SYSTEM_ENABLE_OUT_OE, 1'b0);
        chk("reset pin released", ro_pin, 1'b1);
    endtask : t_good

    task automatic t_pre();
        int n;
        int p;
        do_reset(8'h0A);
        p = n_pre;
        wait_lvl(1'b0, 1'b0, n);
        chk("fault start", n >= LO && n <= HI, 1'b1);
        chk("pretrigger events", n_pre - p, 1);
        wait_lvl(1'b0, 1'b1, n);
        chk("fault reset length", n >= LO && n <= HI, 1'b1);
    endtask : t_pre

    task automatic t_sen_drop();
        int n;
        int p;
        do_reset(8'h2C);
        wait_lvl(1'b1, 1'b1, n);
        p = n_pre;
        fall_tk <= 8'h0A;
        wait_lvl(1'b1, 1'b0, n);
        @(posedge CORE_CLK);
        chk("pretrigger drops enable", n_pre - p, 1);
        chk("reset held while waiting", RESET_OUT_N, 1'b1);
        wait_lvl(1'b0, 1'b0, n);
    endtask : t_sen_drop

    task automatic t_miss();
        int n;
        int m;
        do_reset(8'h2C);
        wait_lvl(1'b1, 1'b1, n);
        m = n_miss;
        fall_tk <= 8'h00;
        wait_lvl(1'b1, 1'b0, n);
        @(posedge CORE_CLK);
        chk("missing trigger events", n_miss - m, 1);
        wait_lvl(1'b0, 1'b0, n);
        wait_lvl(1'b0, 1'b1, n);
        chk("fault reset length", n >= LO && n <= HI, 1'b1);
        wait_lvl(1'b0, 1'b0, n);
        chk("window after release", n >= LO && n <= HI, 1'b1);
    endtask : t_miss

    task automatic t_supply();
        int n;
        int lows;
        int d;
        do_reset(8'h2C);
        wait_lvl(1'b1, 1'b1, n);
        d = n_pd;
        SUPPLY_LOW <= 1'b1;
        repeat (RC / 2) @(posedge CORE_CLK);
        SUPPLY_LOW <= 1'b0;
        run(4 * RC, lows);
        chk("short dip ignored", lows, 0);
        SUPPLY_LOW <= 1'b1;
        run(RC + 8, lows);
        chk("long dip resets", RESET_OUT_N, 1'b0);
        chk("dip drops enable", SYSTEM_ENABLE_OUT, 1'b0);
        chk("enable pin driven", SYSTEM_ENABLE_OUT_OE, 1'b1);
        chk("power-down events", n_pd - d, 1);
        SUPPLY_LOW <= 1'b0;
        wait_lvl(1'b0, 1'b1, n);
        chk("delay after recovery", n >= LO && n <= HI, 1'b1);
    endtask : t_supply

    initial begin
        RST_N = 1'b0;
        SUPPLY_LOW = 1'b0;
        fall_tk = 8'h2C;
        n_mismatch = 0;
        checks = 0;
        cyc = 0;
        n_pre = 0;
        n_miss = 0;
        n_pd = 0;
        t_good(8'h2C);
        t_good(8'h1F);
        t_good(8'h3A);
        t_pre();
        t_sen_drop();
        t_miss();
        t_supply();
        conclude();
    end
endmodule : tb_window_watchdog_reset_gen
`default_nettype wire
